// >>> src/pcv_map.vh
`ifndef PCV_MAP_VH
`define PCV_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PCV_OFS_CTRL      8'h00
`define PCV_OFS_CMD       8'h04
`define PCV_OFS_STARTVEL  8'h08
`define PCV_OFS_TOPVEL    8'h0c
`define PCV_OFS_ACCEL     8'h10
`define PCV_OFS_DIST      8'h14
`define PCV_OFS_SYNC      8'h18
`define PCV_OFS_STATUS    8'h1c
`define PCV_OFS_CURVEL    8'h20
`define PCV_OFS_PCOUNT    8'h24
`define PCV_OFS_GPO       8'h28
`define PCV_OFS_GPI       8'h2c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCV_CTRL_FMT_LO   0
`define PCV_CTRL_FMT_HI   2
`define PCV_CTRL_INV      3
`define PCV_CTRL_DIRNEG   4
`define PCV_CTRL_ARM      5
`define PCV_CTRL_LOCK     6
`define PCV_CMD_LINRUN    0
`define PCV_CMD_SRUN      1
`define PCV_CMD_VCHG      2
`define PCV_CMD_RHALT     3
`define PCV_CMD_EHALT     4
`define PCV_SYNC_LAUNCH   0
`define PCV_SYNC_HALT     1
`define PCV_GPO_TTL_LO    0
`define PCV_GPO_ISO_LO    8

// ----------------------------------------------------------------
// Codes, reset values and timing
// ----------------------------------------------------------------
`define PCV_FMT_DUAL      3'h4
`define PCV_CTRL_RST      32'h00000000
`define PCV_VEL_RST       32'h00000000
`define PCV_ACCEL_RST     32'h00000001
`define PCV_RAMP_TICK_NS  1000
`define PCV_CLK_NS        20
`define PCV_RESP_OKAY     2'h0
`define PCV_RESP_SLVERR   2'h2

`endif

// >>> src/pcv_pulse_gen.v
`timescale 1ns/1ns

`include "pcv_map.vh"

module pcv_pulse_gen #(
	parameter VEL_W = 32
) (
	// Clock and reset
	input  wire             ref_clk,
	input  wire             rst,
	// Rate and format
	input  wire             clear,
	input  wire [VEL_W-1:0] rateInc,
	input  wire [2:0]       fmtCode,
	input  wire             invert,
	input  wire             dirNeg,
	// Pins and count
	output reg              pinA_ff,
	output reg              pinB_ff,
	output reg  [31:0]      pulseCnt_ff,
	input  wire             cntClear
);

	reg  [VEL_W-1:0] acc_ff;
	wire [VEL_W-1:0] nxt_acc;
	wire             nxt_ph;
	wire             dual;

	// Phase accumulator: each rise of the top bit is one pulse, so the
	// pulse rate follows the increment and each pulse is counted once.
	assign nxt_acc = clear ? {VEL_W{1'b0}} : acc_ff + rateInc;
	assign nxt_ph  = nxt_acc[VEL_W-1];
	assign dual    = (fmtCode == `PCV_FMT_DUAL);

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			acc_ff      <= {VEL_W{1'b0}};
			pinA_ff     <= 1'b0;
			pinB_ff     <= 1'b0;
			pulseCnt_ff <= 32'h00000000;
		end
		else
		begin
			acc_ff <= nxt_acc;
			if (cntClear)
				pulseCnt_ff <= 32'h00000000;
			else if (nxt_ph & ~acc_ff[VEL_W-1])
				pulseCnt_ff <= pulseCnt_ff + 32'h00000001;
			if (dual)
			begin
				// Idle pin rests at the inactive level set by invert
				pinA_ff <= (nxt_ph & ~dirNeg) ^ invert;
				pinB_ff <= (nxt_ph & dirNeg) ^ invert;
			end
			else
			begin
				pinA_ff <= nxt_ph ^ invert;
				pinB_ff <= dirNeg;
			end
		end
	end

endmodule // pcv_pulse_gen

// >>> src/pcv_axis_top.v
`timescale 1ns/1ns

`include "pcv_map.vh"

// Summary of operation
// - One shared launch net and one shared halt net serve every axis.
// - Each axis drives and senses both shared lines.
// - Shared nets of joined cards are wired together.
// - Six logic-level outputs set directly by software.
// - Variant adds eight isolated outputs and eight inputs for software.
// - Two command pins, format selectable: step/direction or dual pulse.
// - Format code 4: pin A pulses forward, pin B pulses reverse.
// - Step/direction: pin A pulses, pin B holds the direction level.
// - Pulse count equals distance; pulse rate equals commanded speed.
// - Pulse train polarity selectable.
// - Velocity mode ramps start to top velocity, linear or S-curve.
// - Rate holds at top velocity until new speed or stop.
// - Ramped stop decelerates to start velocity, then pulses cease.
// - Emergency stop ceases pulses at once, no ramp.
// - Speed changes and ramped stops reuse the starting move's shape.
// - Speed change and stop also work during preset-distance moves.
module pcv_axis_top #(
	parameter VEL_W = 32,
	parameter TTL_N = 6,
	parameter ISO_N = 8
) (
	// Clock and reset
	input  wire             ref_clk,
	input  wire             rst,
	// AXI4-Lite write address and data
	input  wire             s_axi_awvalid,
	output reg              s_axi_awready,
	input  wire [7:0]       s_axi_awaddr,
	input  wire             s_axi_wvalid,
	output reg              s_axi_wready,
	input  wire [31:0]      s_axi_wdata,
	input  wire [3:0]       s_axi_wstrb,
	// AXI4-Lite write response
	output reg              s_axi_bvalid,
	input  wire             s_axi_bready,
	output reg  [1:0]       s_axi_bresp,
	// AXI4-Lite read
	input  wire             s_axi_arvalid,
	output reg              s_axi_arready,
	input  wire [7:0]       s_axi_araddr,
	output reg              s_axi_rvalid,
	input  wire             s_axi_rready,
	output reg  [31:0]      s_axi_rdata,
	output reg  [1:0]       s_axi_rresp,
	// Shared launch and halt lines, open drain
	input  wire             syncLaunchLineIn,
	output reg              syncLaunchLineOut_ff,
	output reg              syncLaunchLineOe_n_ff,
	input  wire             syncHaltLineIn,
	output reg              syncHaltLineOut_ff,
	output reg              syncHaltLineOe_n_ff,
	// Command pins
	output wire             cmdPinA,
	output wire             cmdPinB,
	// General purpose I/O
	output reg  [TTL_N-1:0] ttlOutputBit_ff,
	output reg  [ISO_N-1:0] isolatedOutputBit_ff,
	input  wire [ISO_N-1:0] isolatedInputBit
);

	localparam RAMP_CYC = `PCV_RAMP_TICK_NS / `PCV_CLK_NS;
	localparam S_IDLE = 2'h0;
	localparam S_WAIT = 2'h1;
	localparam S_RUN  = 2'h2;
	localparam S_STOP = 2'h3;

	// Byte-lane merge for the writable registers other than CMD and GPO
	function [31:0] merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0]  st;
		integer      i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (st[i])
					merge[i*8 +: 8] = wd[i*8 +: 8];
		end
	endfunction

	// ------------------------------------------------------------
	// Register file and bus slave
	// ------------------------------------------------------------
	reg  [31:0]      ctrl_ff;
	reg  [31:0]      startVel_ff;
	reg  [31:0]      topVelocity_ff;
	reg  [31:0]      accel_ff;
	reg  [31:0]      dist_ff;
	reg  [31:0]      sync_ff;
	reg  [4:0]       cmd_ff;
	reg  [7:0]       awAddr_ff;
	reg              awHeld_ff;
	reg  [31:0]      wData_ff;
	reg  [3:0]       wStrb_ff;
	reg              wHeld_ff;
	reg  [31:0]      rdMux;
	reg              rdHit;
	reg              wrHit;
	reg  [1:0]       state_ff;
	reg  [VEL_W-1:0] vel_ff;
	reg  [ISO_N-1:0] gpiS1_ff;
	reg  [ISO_N-1:0] gpiS2_ff;
	wire [31:0]      pulseCnt;
	wire             launchLvl;
	wire             haltLvl;

	always @*
	begin
		rdHit = 1'b1;
		rdMux = 32'h00000000;
		case (s_axi_araddr)
		`PCV_OFS_CTRL:     rdMux = ctrl_ff;
		`PCV_OFS_CMD:      rdMux = 32'h00000000;
		`PCV_OFS_STARTVEL: rdMux = startVel_ff;
		`PCV_OFS_TOPVEL:   rdMux = topVelocity_ff;
		`PCV_OFS_ACCEL:    rdMux = accel_ff;
		`PCV_OFS_DIST:     rdMux = dist_ff;
		`PCV_OFS_SYNC:     rdMux = sync_ff;
		`PCV_OFS_STATUS:
			rdMux = {27'h0, (state_ff != S_IDLE), haltLvl, launchLvl,
				state_ff};
		`PCV_OFS_CURVEL:   rdMux = vel_ff;
		`PCV_OFS_PCOUNT:   rdMux = pulseCnt;
		`PCV_OFS_GPO:
			rdMux = {16'h0, isolatedOutputBit_ff, 2'h0, ttlOutputBit_ff};
		`PCV_OFS_GPI:      rdMux = {24'h0, gpiS2_ff};
		default:           rdHit = 1'b0;
		endcase
	end

	always @*
	begin
		case (awAddr_ff)
		`PCV_OFS_CTRL, `PCV_OFS_CMD, `PCV_OFS_STARTVEL, `PCV_OFS_TOPVEL,
		`PCV_OFS_ACCEL, `PCV_OFS_DIST, `PCV_OFS_SYNC, `PCV_OFS_GPO:
			wrHit = 1'b1;
		default:
			wrHit = 1'b0;
		endcase
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_awready        <= 1'b1;
			s_axi_wready         <= 1'b1;
			s_axi_bvalid         <= 1'b0;
			s_axi_bresp          <= `PCV_RESP_OKAY;
			s_axi_arready        <= 1'b1;
			s_axi_rvalid         <= 1'b0;
			s_axi_rdata          <= 32'h00000000;
			s_axi_rresp          <= `PCV_RESP_OKAY;
			awAddr_ff            <= 8'h00;
			awHeld_ff            <= 1'b0;
			wData_ff             <= 32'h00000000;
			wStrb_ff             <= 4'h0;
			wHeld_ff             <= 1'b0;
			ctrl_ff              <= `PCV_CTRL_RST;
			startVel_ff          <= `PCV_VEL_RST;
			topVelocity_ff       <= `PCV_VEL_RST;
			accel_ff             <= `PCV_ACCEL_RST;
			dist_ff              <= 32'h00000000;
			sync_ff              <= 32'h00000000;
			cmd_ff               <= 5'h00;
			ttlOutputBit_ff      <= {TTL_N{1'b0}};
			isolatedOutputBit_ff <= {ISO_N{1'b0}};
		end
		else
		begin
			cmd_ff <= 5'h00;
			if (s_axi_awvalid & s_axi_awready)
			begin
				awAddr_ff     <= s_axi_awaddr;
				awHeld_ff     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				wData_ff     <= s_axi_wdata;
				wStrb_ff     <= s_axi_wstrb;
				wHeld_ff     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (awHeld_ff & wHeld_ff & ~s_axi_bvalid)
			begin
				awHeld_ff    <= 1'b0;
				wHeld_ff     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrHit ? `PCV_RESP_OKAY : `PCV_RESP_SLVERR;
				case (awAddr_ff)
				`PCV_OFS_CTRL:
					ctrl_ff <= merge(ctrl_ff, wData_ff, wStrb_ff);
				`PCV_OFS_CMD:
					if (wStrb_ff[0])
						cmd_ff <= wData_ff[4:0];
				`PCV_OFS_STARTVEL:
					startVel_ff <= merge(startVel_ff, wData_ff, wStrb_ff);
				`PCV_OFS_TOPVEL:
					topVelocity_ff <= merge(topVelocity_ff, wData_ff,
						wStrb_ff);
				`PCV_OFS_ACCEL:
					accel_ff <= merge(accel_ff, wData_ff, wStrb_ff);
				`PCV_OFS_DIST:
					dist_ff <= merge(dist_ff, wData_ff, wStrb_ff);
				`PCV_OFS_SYNC:
					sync_ff <= merge(sync_ff, wData_ff, wStrb_ff);
				`PCV_OFS_GPO:
				begin
					if (wStrb_ff[0])
						ttlOutputBit_ff <= wData_ff[TTL_N-1:0];
					if (wStrb_ff[1])
						isolatedOutputBit_ff <=
							wData_ff[`PCV_GPO_ISO_LO +: ISO_N];
				end
				default:
					s_axi_bresp <= `PCV_RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid & s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rdMux;
				s_axi_rresp   <= rdHit ? `PCV_RESP_OKAY : `PCV_RESP_SLVERR;
			end
			if (s_axi_rvalid & s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Shared lines and input synchronisers
	// ------------------------------------------------------------
	reg  [1:0] launchS_ff;
	reg  [1:0] haltS_ff;
	reg        launchPrev_ff;

	// Active low: a line reads asserted when any party holds it low
	assign launchLvl = ~launchS_ff[1];
	assign haltLvl   = ~haltS_ff[1];

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			syncLaunchLineOut_ff  <= 1'b0;
			syncLaunchLineOe_n_ff <= 1'b1;
			syncHaltLineOut_ff    <= 1'b0;
			syncHaltLineOe_n_ff   <= 1'b1;
			launchS_ff            <= 2'h3;
			haltS_ff              <= 2'h3;
			launchPrev_ff         <= 1'b0;
			gpiS1_ff              <= {ISO_N{1'b0}};
			gpiS2_ff              <= {ISO_N{1'b0}};
		end
		else
		begin
			// Only ever drive low; release lets the pull-up win
			syncLaunchLineOut_ff  <= 1'b0;
			syncLaunchLineOe_n_ff <= ~sync_ff[`PCV_SYNC_LAUNCH];
			syncHaltLineOut_ff    <= 1'b0;
			syncHaltLineOe_n_ff   <= ~sync_ff[`PCV_SYNC_HALT];
			launchS_ff <= {launchS_ff[0], syncLaunchLineIn};
			haltS_ff   <= {haltS_ff[0], syncHaltLineIn};
			launchPrev_ff <= launchLvl;
			gpiS1_ff <= isolatedInputBit;
			gpiS2_ff <= gpiS1_ff;
		end
	end

	// ------------------------------------------------------------
	// Velocity profile
	// ------------------------------------------------------------
	reg  [VEL_W-1:0] target_ff;
	reg  [VEL_W-1:0] sStep_ff;
	reg              sShape_ff;
	reg              dirNeg_ff;
	reg  [15:0]      tick_ff;
	reg  [VEL_W-1:0] step;
	reg  [VEL_W-1:0] diff;
	reg              up;
	wire             tick;
	wire             launchEdge;
	wire             eStop;
	wire             distDone;
	wire             startCmd;

	assign tick       = (tick_ff == RAMP_CYC[15:0] - 16'h0001);
	assign launchEdge = launchLvl & ~launchPrev_ff;
	assign eStop      = cmd_ff[`PCV_CMD_EHALT] | haltLvl;
	assign startCmd   = cmd_ff[`PCV_CMD_LINRUN] | cmd_ff[`PCV_CMD_SRUN];
	assign distDone   = (dist_ff != 32'h00000000) && (pulseCnt >= dist_ff);

	// S-curve eases in by growing the step and eases out by limiting it
	// to a quarter of the gap plus one, so the approach to target is smooth.
	always @*
	begin
		up   = (target_ff > vel_ff);
		diff = up ? target_ff - vel_ff : vel_ff - target_ff;
		step = accel_ff;
		if (sShape_ff)
		begin
			step = (sStep_ff < accel_ff) ? sStep_ff : accel_ff;
			if (step > (diff >> 2) + 32'h00000001)
				step = (diff >> 2) + 32'h00000001;
		end
		if (step > diff)
			step = diff;
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff  <= S_IDLE;
			vel_ff    <= {VEL_W{1'b0}};
			target_ff <= {VEL_W{1'b0}};
			sStep_ff  <= {VEL_W{1'b0}};
			sShape_ff <= 1'b0;
			dirNeg_ff <= 1'b0;
			tick_ff   <= 16'h0000;
		end
		else
		begin
			tick_ff <= tick ? 16'h0000 : tick_ff + 16'h0001;
			case (state_ff)
			S_IDLE:
				if (startCmd & ~haltLvl)
				begin
					// Shape and direction latch for the whole move
					sShape_ff <= cmd_ff[`PCV_CMD_SRUN];
					dirNeg_ff <= ctrl_ff[`PCV_CTRL_DIRNEG];
					target_ff <= topVelocity_ff;
					sStep_ff  <= 32'h00000001;
					state_ff  <= ctrl_ff[`PCV_CTRL_ARM] ? S_WAIT : S_RUN;
					if (~ctrl_ff[`PCV_CTRL_ARM])
						vel_ff <= startVel_ff;
				end
			S_WAIT:
				if (eStop | cmd_ff[`PCV_CMD_RHALT])
					state_ff <= S_IDLE;
				else if (launchEdge)
				begin
					vel_ff   <= startVel_ff;
					state_ff <= S_RUN;
				end
			S_RUN, S_STOP:
				if (eStop | distDone)
				begin
					vel_ff   <= {VEL_W{1'b0}};
					state_ff <= S_IDLE;
				end
				else if (cmd_ff[`PCV_CMD_RHALT])
				begin
					target_ff <= startVel_ff;
					sStep_ff  <= 32'h00000001;
					state_ff  <= S_STOP;
				end
				else if (cmd_ff[`PCV_CMD_VCHG] & ctrl_ff[`PCV_CTRL_LOCK] &
					(state_ff == S_RUN))
				begin
					// Needs the locked speed range
					target_ff <= topVelocity_ff;
					sStep_ff  <= 32'h00000001;
				end
				else if (state_ff == S_STOP && vel_ff <= target_ff)
				begin
					vel_ff   <= {VEL_W{1'b0}};
					state_ff <= S_IDLE;
				end
				else if (tick & (diff != {VEL_W{1'b0}}))
				begin
					// Holds once target is reached
					vel_ff   <= up ? vel_ff + step : vel_ff - step;
					sStep_ff <= sStep_ff + 32'h00000001;
				end
			default:
				state_ff <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pulse output
	// ------------------------------------------------------------
	pcv_pulse_gen #(
		.VEL_W(VEL_W)
	) u_gen (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.clear      (state_ff == S_IDLE || state_ff == S_WAIT),
		.rateInc    (vel_ff),
		.fmtCode    (ctrl_ff[`PCV_CTRL_FMT_HI:`PCV_CTRL_FMT_LO]),
		.invert     (ctrl_ff[`PCV_CTRL_INV]),
		.dirNeg     (dirNeg_ff),
		.pinA_ff    (cmdPinA),
		.pinB_ff    (cmdPinB),
		.pulseCnt_ff(pulseCnt),
		.cntClear   (startCmd && state_ff == S_IDLE)
	);

endmodule // pcv_axis_top

// >>> testbench/pcv_axis_sva.sv
`timescale 1ns/1ns

module pcv_axis_sva (
	// Clock and reset
	input wire        ref_clk,
	input wire        rst,
	// Register bus
	input wire        s_axi_awready,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	// Shared lines and pins
	input wire        syncLaunchLineOut_ff,
	input wire        syncHaltLineOut_ff,
	input wire        syncHaltLineIn,
	input wire        cmdPinA,
	input wire        cmdPinB
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// Shared lines and pins
	// ------------------------------------------------------------
	AST_LAUNCH_LOW: assert property (syncLaunchLineOut_ff == 1'b0)
		else $error("launch line data not low");
	AST_HALT_LOW: assert property (syncHaltLineOut_ff == 1'b0)
		else $error("halt line data not low");
	AST_HALT_STOP: assert property (!syncHaltLineIn [*8] |->
		$stable(cmdPinA) && $stable(cmdPinB))
		else $error("pins move while halt line held");

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_B_ORDER: assert property ($rose(s_axi_bvalid) |->
		!$past(s_axi_awready) && !$past(s_axi_wready))
		else $error("response before address and data");
	AST_AW_REFUSE: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("new write taken while response pending");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready)
		else $error("read answer not one cycle after address");
	AST_UNMAP: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
		s_axi_rdata == 32'h0)
		else $error("error read carries data");

	COV_SLVERR: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
	COV_HALT: cover property (!syncHaltLineIn [*8]);
endmodule // pcv_axis_sva

bind pcv_axis_top pcv_axis_sva chk (
	.ref_clk             (ref_clk),
	.rst                 (rst),
	.s_axi_awready       (s_axi_awready),
	.s_axi_wready        (s_axi_wready),
	.s_axi_bvalid        (s_axi_bvalid),
	.s_axi_bready        (s_axi_bready),
	.s_axi_bresp         (s_axi_bresp),
	.s_axi_arvalid       (s_axi_arvalid),
	.s_axi_arready       (s_axi_arready),
	.s_axi_rvalid        (s_axi_rvalid),
	.s_axi_rready        (s_axi_rready),
	.s_axi_rdata         (s_axi_rdata),
	.s_axi_rresp         (s_axi_rresp),
	.syncLaunchLineOut_ff(syncLaunchLineOut_ff),
	.syncHaltLineOut_ff  (syncHaltLineOut_ff),
	.syncHaltLineIn      (syncHaltLineIn),
	.cmdPinA             (cmdPinA),
	.cmdPinB             (cmdPinB)
);

// >>> testbench/pcv_drive_model.sv
`timescale 1ns/1ns

module pcv_drive_model (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst,
	// Pins and expected format
	input  wire        cmdPinA,
	input  wire        cmdPinB,
	input  wire        dualMode,
	input  wire        invert,
	// Pulse totals
	output logic [31:0] fwdCnt,
	output logic [31:0] revCnt
);
	logic lastA;
	logic lastB;
	// Active edge is the rising edge of the de-inverted pin
	wire  a = cmdPinA ^ invert;
	wire  b = cmdPinB ^ invert;

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			{fwdCnt, revCnt} <= 64'h0;
			{lastA, lastB} <= 2'h0;
		end
		else
		begin
			lastA <= a;
			lastB <= b;
			if (a && !lastA && !dualMode && cmdPinB)
				revCnt <= revCnt + 32'h1;
			else if (a && !lastA)
				fwdCnt <= fwdCnt + 32'h1;
			if (dualMode && b && !lastB)
				revCnt <= revCnt + 32'h1;
		end
	end
endmodule // pcv_drive_model

// >>> testbench/testbench.sv
`timescale 1ns/1ns

`include "pcv_map.vh"

module testbench;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        ref_clk, rst, awVal, wVal, bRdy, arVal, rRdy;
	logic [7:0]  awAddr, arAddr, isoIn;
	logic [31:0] wDat, rdat, fB, rB;
	logic [3:0]  wStb;
	logic [1:0]  resp;
	logic        extHalt, dualMode, invert;
	wire         awRdy, wRdy, bVal, arRdy, rVal, lOut, lOen, hOut, hOen;
	wire         pinA, pinB;
	wire  [1:0]  bResp, rResp;
	wire  [31:0] rDat, fwdCnt, revCnt;
	wire  [5:0]  ttl;
	wire  [7:0]  iso;
	int          bad_count, n_tests;
	// Pulled-up nets: any party pulls low, nobody drives high
	wire         lIn = lOen;
	wire         hIn = hOen & !extHalt;

	pcv_axis_top DUT (
		.ref_clk(ref_clk), .rst(rst),
		.s_axi_awvalid(awVal), .s_axi_awready(awRdy), .s_axi_awaddr(awAddr),
		.s_axi_wvalid(wVal), .s_axi_wready(wRdy), .s_axi_wdata(wDat),
		.s_axi_wstrb(wStb), .s_axi_bvalid(bVal), .s_axi_bready(bRdy),
		.s_axi_bresp(bResp), .s_axi_arvalid(arVal), .s_axi_arready(arRdy),
		.s_axi_araddr(arAddr), .s_axi_rvalid(rVal), .s_axi_rready(rRdy),
		.s_axi_rdata(rDat), .s_axi_rresp(rResp),
		.syncLaunchLineIn(lIn), .syncLaunchLineOut_ff(lOut),
		.syncLaunchLineOe_n_ff(lOen), .syncHaltLineIn(hIn),
		.syncHaltLineOut_ff(hOut), .syncHaltLineOe_n_ff(hOen),
		.cmdPinA(pinA), .cmdPinB(pinB), .ttlOutputBit_ff(ttl),
		.isolatedOutputBit_ff(iso), .isolatedInputBit(isoIn));

	pcv_drive_model drv (.ref_clk(ref_clk), .rst(rst), .cmdPinA(pinA),
		.cmdPinB(pinB), .dualMode(dualMode), .invert(invert),
		.fwdCnt(fwdCnt), .revCnt(revCnt));

	// ------------------------------------------------------------
	// Bus tasks and checks
	// ------------------------------------------------------------
	// Waits as long as the slave needs; only the watchdog ends a hang
	task wr(input [7:0] a, input [31:0] d, input [3:0] s);
		begin
			@(posedge ref_clk);
			{awVal, wVal, bRdy} <= 3'h7;
			{awAddr, wDat, wStb} <= {a, d, s};
			while (awVal || wVal || !bVal)
			begin
				@(posedge ref_clk);
				if (awRdy) awVal <= 1'b0;
				if (wRdy) wVal <= 1'b0;
			end
			resp = bResp;
			bRdy <= 1'b0;
		end
	endtask

	task rd(input [7:0] a);
		begin
			@(posedge ref_clk);
			{arVal, rRdy} <= 2'h3;
			arAddr <= a;
			while (arVal || !rVal)
			begin
				@(posedge ref_clk);
				if (arRdy) arVal <= 1'b0;
			end
			{rdat, resp} = {rDat, rResp};
			rRdy <= 1'b0;
		end
	endtask

	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			n_tests++;
			if (g !== e)
			begin
				bad_count++;
				$display("MISMATCH %s exp %h got %h", nm, e, g);
			end
		end
	endtask

	task rdChk(input [7:0] a, input [31:0] e, input string nm);
		begin
			rd(a);
			chk(nm, e, rdat);
		end
	endtask

	// Bases are taken after the format settles: a live change can glitch
	task runMove(input [31:0] c, sv, tv, ds, cm);
		begin
			wr(`PCV_OFS_CTRL, c, 4'hf);
			dualMode <= c[2:0] == `PCV_FMT_DUAL;
			invert <= c[`PCV_CTRL_INV];
			wr(`PCV_OFS_STARTVEL, sv, 4'hf);
			wr(`PCV_OFS_TOPVEL, tv, 4'hf);
			wr(`PCV_OFS_DIST, ds, 4'hf);
			{fB, rB} = {fwdCnt, revCnt};
			wr(`PCV_OFS_CMD, cm, 4'hf);
		end
	endtask

	task waitIdle;
		begin
			do
				rd(`PCV_OFS_STATUS);
			while (rdat[4]);
		end
	endtask

	task complete_run;
		begin
			$display("checks %0d mismatches %0d", n_tests, bad_count);
			if (bad_count == 0 && n_tests > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog and tests
	// ------------------------------------------------------------
	initial
	begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end

	initial
	begin
		#800000;
		bad_count++;
		complete_run;
	end

	initial
	begin
		{rst, awVal, wVal, bRdy, arVal, rRdy} = 6'h20;
		{awAddr, arAddr, wDat, wStb, isoIn} = 0;
		{extHalt, dualMode, invert, bad_count, n_tests} = 0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		rdChk(`PCV_OFS_CTRL, `PCV_CTRL_RST, "ctrl reset");
		rdChk(`PCV_OFS_ACCEL, `PCV_ACCEL_RST, "accel reset");
		rdChk(`PCV_OFS_TOPVEL, `PCV_VEL_RST, "top reset");
		isoIn <= 8'h5c;
		wr(`PCV_OFS_GPO, 32'h0000a53f, 4'hf);
		chk("ttl out", 32'h3f, {26'h0, ttl});
		chk("iso out", 32'ha5, {24'h0, iso});
		wr(`PCV_OFS_GPO, 32'h0, 4'h2);
		chk("iso lane", 32'h0, {24'h0, iso});
		chk("ttl kept", 32'h3f, {26'h0, ttl});
		rdChk(`PCV_OFS_GPI, 32'h5c, "inputs");
		rd(8'h40);
		chk("unmapped rresp", `PCV_RESP_SLVERR, {30'h0, resp});
		wr(8'h44, 32'h1, 4'hf);
		chk("unmapped bresp", `PCV_RESP_SLVERR, {30'h0, resp});
		$display("test map done");
		wr(`PCV_OFS_ACCEL, 32'h04000000, 4'hf);
		runMove(32'h10, 32'h10000000, 32'h10000000, 32'd10, 32'h1);
		waitIdle;
		chk("rev pulses", 32'd10, revCnt - rB);
		chk("fwd pulses", 32'd0, fwdCnt - fB);
		rdChk(`PCV_OFS_PCOUNT, 32'd10, "pulse count");
		runMove(32'h0c, 32'h10000000, 32'h10000000, 32'd7, 32'h2);
		waitIdle;
		chk("cw pulses", 32'd7, fwdCnt - fB);
		chk("ccw pulses", 32'd0, revCnt - rB);
		chk("idle level", 32'h3, {30'h0, pinB, pinA});
		$display("test format done");
		runMove(32'h0, 32'h10000000, 32'h20000000, 32'd0, 32'h1);
		repeat (400) @(posedge ref_clk);
		rdChk(`PCV_OFS_CURVEL, 32'h20000000, "top vel");
		fB = fwdCnt;
		repeat (256) @(posedge ref_clk);
		chk("rate", 32'd32, fwdCnt - fB);
		wr(`PCV_OFS_CTRL, 32'h40, 4'hf);
		wr(`PCV_OFS_TOPVEL, 32'h18000000, 4'hf);
		wr(`PCV_OFS_CMD, 32'h4, 4'hf);
		repeat (400) @(posedge ref_clk);
		rdChk(`PCV_OFS_CURVEL, 32'h18000000, "new vel");
		wr(`PCV_OFS_CMD, 32'h8, 4'hf);
		rd(`PCV_OFS_STATUS);
		chk("ramping", 32'h3, {30'h0, rdat[1:0]});
		waitIdle;
		fB = fwdCnt;
		repeat (100) @(posedge ref_clk);
		chk("ceased", 32'h0, fwdCnt - fB);
		$display("test velocity done");
		runMove(32'h0, 32'h10000000, 32'h20000000, 32'd5000, 32'h2);
		repeat (100) @(posedge ref_clk);
		extHalt <= 1'b1;
		repeat (10) @(posedge ref_clk);
		fB = fwdCnt;
		repeat (100) @(posedge ref_clk);
		chk("halt line stop", 32'h0, fwdCnt - fB);
		rd(`PCV_OFS_STATUS);
		chk("halt status", 32'h4, {29'h0, rdat[3], rdat[1:0]});
		extHalt <= 1'b0;
		repeat (5) @(posedge ref_clk);
		runMove(32'h0, 32'h10000000, 32'h20000000, 32'd5000, 32'h1);
		repeat (50) @(posedge ref_clk);
		wr(`PCV_OFS_CMD, 32'h10, 4'hf);
		rd(`PCV_OFS_STATUS);
		chk("emergency", 32'h0, {30'h0, rdat[1:0]});
		$display("test stop done");
		runMove(32'h20, 32'h10000000, 32'h10000000, 32'd0, 32'h1);
		rd(`PCV_OFS_STATUS);
		chk("armed wait", 32'h1, {30'h0, rdat[1:0]});
		wr(`PCV_OFS_SYNC, 32'h1, 4'hf);
		@(negedge ref_clk);
		chk("launch drive", 32'h0, {31'h0, lOen});
		repeat (10) @(posedge ref_clk);
		rd(`PCV_OFS_STATUS);
		chk("launched", 32'h6, {29'h0, rdat[2], rdat[1:0]});
		wr(`PCV_OFS_SYNC, 32'h2, 4'hf);
		@(negedge ref_clk);
		chk("halt drive", 32'h0, {31'h0, hOen});
		waitIdle;
		chk("own halt", 32'h8, {28'h0, rdat[3:0]});
		wr(`PCV_OFS_SYNC, 32'h0, 4'hf);
		$display("test launch done");
		complete_run;
	end
endmodule // testbench
